// ==== rtl/arlt_timer.sv ====
/*
 * Auto-reload timer with capture: 16-bit or split 8-bit auto-reload,
 * external oscillator capture against the core clock.
 * Assumes a single-cycle byte register port from the core and an
 * asynchronous external oscillator pin.
 */
// Functional notes
// - sixteen-bit counter from low and high bytes, 16-bit or split reload
// - clocks: core, core/12, synchronised external/8
// - 16-bit rollover reloads both bytes and sets high flag
// - 16-bit mode overflow requests interrupt when timer irq enabled
// - 16-bit mode low byte rollover interrupts if low irq enabled too
// - split mode: bytes independent, each reloads from its own reload byte
// - split mode: run bit gates high byte only, low runs always
// - per-byte select 1 core clock, else external select picks /12 or /8
// - split mode: high rollover sets high flag, low rollover low flag
// - split mode interrupts on high, or either byte with low irq enable
// - hardware never clears flags, software clears and inspects both
// - capture copies counter into reload pair, sets high flag
// - capture event on each falling edge of external/8
// - capture mode counts on core or core/12 per low select
// - low select 1 with capture: count each core clock, capture each ext/8
// - split select bit 3, low irq enable bit 5 of control
// - control at 0xc8 page 0x00, bit addressable, resets to zero
// - capture enable 0 disables capture, 1 enables it when split is clear
// - run bit 1 enables counting
`timescale 1ns/1ps
`default_nettype none
module arlt_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire arlt_pkg::arlt_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // external oscillator pin
    input wire logic ext_osc,
    // interrupt request
    output logic timer_irq
);
    import arlt_pkg::*;

    // ==========================================================
    // registers
    logic [7:0] control_reg;
    logic [7:0] clock_control_reg;
    logic [7:0] global_irq_reg;
    logic [7:0] count_low_reg;
    logic [7:0] count_high_reg;
    logic [7:0] reload_low_reg;
    logic [7:0] reload_high_reg;
    logic [3:0] core_div_reg;
    logic core_tick_reg;
    logic [2:0] ext_sync_reg;
    logic ext_level_reg;
    logic [2:0] ext_div_reg;
    logic ext_tick_reg;
    logic ext_fall_reg;

    function automatic logic sel(input logic [7:0] a);
        sel = sfr_req.page == ARLT_PAGE_TIMER && sfr_req.addr == a;
    endfunction : sel

    function automatic logic tick_for(input logic byte_core_sel);
        if (byte_core_sel) begin
            tick_for = 1'b1;
        end else if (control_reg[ARLT_BIT_EXT_CLK]) begin
            tick_for = ext_tick_reg;
        end else begin
            tick_for = core_tick_reg;
        end
    endfunction : tick_for

    logic wr_control, wr_rl_low, wr_rl_high, wr_cnt_low, wr_cnt_high;
    assign wr_control = sfr_req.wr && sel(ARLT_ADDR_CONTROL);
    assign wr_rl_low = sfr_req.wr && sel(ARLT_ADDR_RELOAD_LOW);
    assign wr_rl_high = sfr_req.wr && sel(ARLT_ADDR_RELOAD_HIGH);
    assign wr_cnt_low = sfr_req.wr && sel(ARLT_ADDR_COUNT_LOW);
    assign wr_cnt_high = sfr_req.wr && sel(ARLT_ADDR_COUNT_HIGH);

    // ==========================================================
    // clock sources
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_div_reg <= 4'h0;
            core_tick_reg <= 1'b0;
        end else begin
            core_tick_reg <= core_div_reg == ARLT_CORE_DIV_LAST;
            core_div_reg <= (core_div_reg == ARLT_CORE_DIV_LAST) ? 4'h0 : core_div_reg + 4'h1;
        end
    end

    // three-stage sync, change accepted once stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync_reg <= 3'h0;
            ext_level_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_osc};
            if (ext_sync_reg[2] == ext_sync_reg[1]) begin
                ext_level_reg <= ext_sync_reg[2];
            end
        end
    end

    logic ext_rise;
    assign ext_rise = (ext_sync_reg[2] == ext_sync_reg[1]) && ext_sync_reg[2] && !ext_level_reg;

    // divide external by 8; falling edge of the divided clock is the capture event
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ext_div_reg <= 3'h0;
            ext_tick_reg <= 1'b0;
            ext_fall_reg <= 1'b0;
        end else begin
            ext_tick_reg <= ext_rise && ext_div_reg == ARLT_EXT_DIV_LAST;
            ext_fall_reg <= ext_rise && ext_div_reg == ARLT_EXT_DIV_LAST;
            if (ext_rise) begin
                ext_div_reg <= ext_div_reg + 3'h1;
            end
        end
    end

    // ==========================================================
    // mode decode
    logic split, capture, run, low_tick, high_tick, cnt_tick;
    assign split = control_reg[ARLT_BIT_SPLIT];
    assign capture = control_reg[ARLT_BIT_CAPTURE_EN] && !split;
    assign run = control_reg[ARLT_BIT_RUN];
    assign low_tick = tick_for(clock_control_reg[ARLT_BIT_LOW_CLK_SEL]);
    assign high_tick = tick_for(clock_control_reg[ARLT_BIT_HIGH_CLK_SEL]);
    // capture mode: ext/8 is the measured clock, so external select picks core/12 only
    assign cnt_tick = capture ?
        (clock_control_reg[ARLT_BIT_LOW_CLK_SEL] | core_tick_reg) : low_tick;

    logic low_adv, high_adv, low_ovf, high_ovf, cap_evt;
    assign low_adv = split ? low_tick : (run && cnt_tick);
    assign high_adv = split ? (run && high_tick) : (low_adv && count_low_reg == 8'hff);
    assign low_ovf = low_adv && count_low_reg == 8'hff;
    assign high_ovf = high_adv && count_high_reg == 8'hff;
    assign cap_evt = capture && ext_fall_reg;

    // ==========================================================
    // counter bytes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_low_reg <= ARLT_BYTE_RESET;
        end else if (wr_cnt_low) begin
            count_low_reg <= sfr_req.wdata;
        end else if (low_adv) begin
            if (low_ovf && split) begin
                count_low_reg <= reload_low_reg;
            end else if (low_ovf && high_ovf) begin
                count_low_reg <= reload_low_reg;
            end else begin
                count_low_reg <= count_low_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_high_reg <= ARLT_BYTE_RESET;
        end else if (wr_cnt_high) begin
            count_high_reg <= sfr_req.wdata;
        end else if (high_adv) begin
            count_high_reg <= high_ovf ? reload_high_reg : count_high_reg + 8'h01;
        end
    end

    // ==========================================================
    // reload bytes, overwritten by capture
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reload_low_reg <= ARLT_BYTE_RESET;
            reload_high_reg <= ARLT_BYTE_RESET;
        end else begin
            if (cap_evt) begin
                reload_low_reg <= count_low_reg;
                reload_high_reg <= count_high_reg;
            end else begin
                if (wr_rl_low) begin
                    reload_low_reg <= sfr_req.wdata;
                end
                if (wr_rl_high) begin
                    reload_high_reg <= sfr_req.wdata;
                end
            end
        end
    end

    // ==========================================================
    // control register; hardware set wins over software clear
    logic set_high, set_low;
    assign set_high = high_ovf || cap_evt;
    assign set_low = low_ovf;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            control_reg <= ARLT_CONTROL_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= sfr_req.wdata & ARLT_CONTROL_WMASK;
            end
            if (set_high) begin
                control_reg[ARLT_BIT_HIGH_FLAG] <= 1'b1;
            end
            if (set_low) begin
                control_reg[ARLT_BIT_LOW_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clock_control_reg <= ARLT_CONTROL_RESET;
            global_irq_reg <= ARLT_CONTROL_RESET;
        end else begin
            if (sfr_req.wr && sfr_req.addr == ARLT_ADDR_CLOCK_CONTROL) begin
                clock_control_reg <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == ARLT_ADDR_GLOBAL_IRQ) begin
                global_irq_reg <= sfr_req.wdata;
            end
        end
    end

    // ==========================================================
    // interrupt request, level from flags
    logic irq_next;
    assign irq_next = global_irq_reg[ARLT_BIT_TIMER_IRQ_EN] &&
        (control_reg[ARLT_BIT_HIGH_FLAG] ||
         (control_reg[ARLT_BIT_LOW_IRQ_EN] && control_reg[ARLT_BIT_LOW_FLAG]));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= irq_next;
        end
    end

    // ==========================================================
    // read data, registered
    logic [7:0] rdata_next;
    always_comb begin
        rdata_next = 8'h00;
        if (sel(ARLT_ADDR_CONTROL)) begin
            rdata_next = control_reg;
        end else if (sel(ARLT_ADDR_RELOAD_LOW)) begin
            rdata_next = reload_low_reg;
        end else if (sel(ARLT_ADDR_RELOAD_HIGH)) begin
            rdata_next = reload_high_reg;
        end else if (sel(ARLT_ADDR_COUNT_LOW)) begin
            rdata_next = count_low_reg;
        end else if (sel(ARLT_ADDR_COUNT_HIGH)) begin
            rdata_next = count_high_reg;
        end else if (sfr_req.addr == ARLT_ADDR_CLOCK_CONTROL) begin
            rdata_next = clock_control_reg;
        end else if (sfr_req.addr == ARLT_ADDR_GLOBAL_IRQ) begin
            rdata_next = global_irq_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            sfr_rdata <= rdata_next;
        end
    end

    // ==========================================================
    // checks
    a_flag_sticky_high: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(control_reg[ARLT_BIT_HIGH_FLAG]) |-> $past(wr_control))
        else $error("high flag cleared without a write");
    a_flag_sticky_low: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(control_reg[ARLT_BIT_LOW_FLAG]) |-> $past(wr_control))
        else $error("low flag cleared without a write");
    a_wide_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!split && high_ovf && !wr_cnt_low && !wr_cnt_high) |=>
        count_low_reg == $past(reload_low_reg) && count_high_reg == $past(reload_high_reg))
        else $error("16-bit reload missed");
    a_high_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        high_ovf |=> control_reg[ARLT_BIT_HIGH_FLAG])
        else $error("high flag not set");
    a_low_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        low_ovf |=> control_reg[ARLT_BIT_LOW_FLAG])
        else $error("low flag not set");
    a_split_low_free: assert property (@(posedge sys_clk) disable iff (!rstn)
        (split && !run && low_tick && !wr_cnt_low && count_low_reg != 8'hff) |=>
        count_low_reg == $past(count_low_reg) + 8'h01)
        else $error("low byte stalled in split mode");
    a_split_high_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        (split && !run && !wr_cnt_high) |=> $stable(count_high_reg))
        else $error("high byte ran without run bit");
    a_capture_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
        cap_evt |=> reload_low_reg == $past(count_low_reg) &&
        reload_high_reg == $past(count_high_reg) && control_reg[ARLT_BIT_HIGH_FLAG])
        else $error("capture did not copy counter");
    sequence s_irq_cause;
        global_irq_reg[ARLT_BIT_TIMER_IRQ_EN] && control_reg[ARLT_BIT_HIGH_FLAG];
    endsequence
    a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_irq_cause |=> timer_irq)
        else $error("interrupt not raised");
    a_irq_low_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!control_reg[ARLT_BIT_HIGH_FLAG] && !control_reg[ARLT_BIT_LOW_IRQ_EN]) |=> !timer_irq)
        else $error("low interrupt not masked");
    // register, clock, capture, reload, counter and interrupt checks
    a_ctl_fixed_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
        (control_reg & ~ARLT_CONTROL_WMASK) == 8'h00)
        else $error("read-only control bit set");
    a_ext_tick_gap: assert property (@(posedge sys_clk) disable iff (!rstn)
        ext_tick_reg |=> (!ext_tick_reg) [*8])
        else $error("external tick too frequent");
    a_no_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!control_reg[ARLT_BIT_CAPTURE_EN] && !wr_rl_low) |=> $stable(reload_low_reg))
        else $error("reload changed with capture off");
    a_capture_needs_edge: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!ext_fall_reg && !wr_rl_high) |=> $stable(reload_high_reg))
        else $error("capture without external edge");
    a_split_low_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
        (split && low_ovf && !wr_cnt_low) |=> count_low_reg == $past(reload_low_reg))
        else $error("split low reload missed");
    a_split_high_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
        (split && high_ovf && !wr_cnt_high) |=> count_high_reg == $past(reload_high_reg))
        else $error("split high reload missed");
    a_low_wrap_wide: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!split && low_ovf && !high_ovf && !wr_cnt_low) |=> count_low_reg == 8'h00)
        else $error("low byte did not wrap in 16-bit mode");
    a_high_carry_wide: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!split && low_ovf && !high_ovf && !wr_cnt_high) |=> count_high_reg == $past(count_high_reg) + 8'h01)
        else $error("high byte missed carry");
    a_irq_either_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
        (global_irq_reg[ARLT_BIT_TIMER_IRQ_EN] && control_reg[ARLT_BIT_LOW_IRQ_EN] &&
        control_reg[ARLT_BIT_LOW_FLAG]) |=> timer_irq)
        else $error("low byte interrupt not raised");
    a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rstn)
        !global_irq_reg[ARLT_BIT_TIMER_IRQ_EN] |=> !timer_irq)
        else $error("interrupt raised while disabled");
    a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
endmodule : arlt_timer
`default_nettype wire

// ==== common/arlt_pkg.sv ====
/*
 * Register map, field layout, reset values and timing counts of the
 * auto-reload timer with capture.
 * Assumes a byte-wide special-function register port with paging.
 */
`default_nettype none
package arlt_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ARLT_PAGE_TIMER = 8'h00;
    localparam logic [7:0] ARLT_ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ARLT_ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ARLT_ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ARLT_ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ARLT_ADDR_COUNT_HIGH = 8'hcd;
    localparam logic [7:0] ARLT_ADDR_CLOCK_CONTROL = 8'h8e;
    localparam logic [7:0] ARLT_ADDR_GLOBAL_IRQ = 8'ha8;
    // ==========================================================
    // control register fields
    localparam int ARLT_BIT_HIGH_FLAG = 7;
    localparam int ARLT_BIT_LOW_FLAG = 6;
    localparam int ARLT_BIT_LOW_IRQ_EN = 5;
    localparam int ARLT_BIT_CAPTURE_EN = 4;
    localparam int ARLT_BIT_SPLIT = 3;
    localparam int ARLT_BIT_RUN = 2;
    localparam int ARLT_BIT_EXT_CLK = 0;
    localparam logic [7:0] ARLT_CONTROL_WMASK = 8'hfd;
    // clock control fields
    localparam int ARLT_BIT_HIGH_CLK_SEL = 5;
    localparam int ARLT_BIT_LOW_CLK_SEL = 4;
    // global irq enable field
    localparam int ARLT_BIT_TIMER_IRQ_EN = 5;
    // ==========================================================
    // reset values
    localparam logic [7:0] ARLT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] ARLT_BYTE_RESET = 8'h00;
    // ==========================================================
    // dividers
    localparam int ARLT_CORE_DIV = 12;
    localparam int ARLT_EXT_DIV = 8;
    localparam logic [3:0] ARLT_CORE_DIV_LAST = 4'(ARLT_CORE_DIV - 1);
    localparam logic [2:0] ARLT_EXT_DIV_LAST = 3'(ARLT_EXT_DIV - 1);
    localparam int ARLT_EXT_HALF = ARLT_EXT_DIV / 2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } arlt_sfr_req_t;
endpackage : arlt_pkg
`default_nettype wire

// ==== test/arlt_osc_model.sv ====
/*
 * External oscillator model driving the timer's oscillator pin.
 * Assumes the bench chooses the half period and whether it runs.
 */
`timescale 1ns/1ps
`default_nettype none
module arlt_osc_model #(
    parameter int HALF_NS = 200
) (
    // control
    input wire logic run,
    // pin
    output logic osc
);
    // square wave while enabled, held low otherwise
    initial begin
        osc = 1'b0;
        forever begin
            #(HALF_NS);
            osc = run ? ~osc : 1'b0;
        end
    end
endmodule : arlt_osc_model
`default_nettype wire

// ==== test/tb_auto_reload_timer_with_capture.sv ====
/*
 * Self-checking bench of the auto-reload timer with capture.
 * Assumes the arlt_pkg register map and the oscillator model.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_auto_reload_timer_with_capture;
    import arlt_pkg::*;
    localparam int EXT_PER = 10;
    logic sys_clk;
    logic rstn;
    logic ext_run;
    logic osc;
    logic irq;
    arlt_sfr_req_t req;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [15:0] lf;
    logic [15:0] c;
    logic [15:0] c1;
    int fails;
    int checked;
    int cyc;
    int divs [3] = '{ARLT_CORE_DIV, ARLT_EXT_DIV * EXT_PER, 1};
    logic [7:0] regs [5] = '{ARLT_ADDR_CONTROL, ARLT_ADDR_RELOAD_LOW,
        ARLT_ADDR_RELOAD_HIGH, ARLT_ADDR_COUNT_LOW, ARLT_ADDR_COUNT_HIGH};

    arlt_timer dut (.sys_clk(sys_clk), .rstn(rstn), .sfr_req(req), .sfr_rdata(rdata),
        .ext_osc(osc), .timer_irq(irq));
    arlt_osc_model #(.HALF_NS(EXT_PER * 20)) osc_m (.run(ext_run), .osc(osc));

    // ====================
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // m = {low irq en, capture, split, run, ext select}
    function automatic logic [7:0] ctl(input logic [1:0] fl, input logic [4:0] m);
        return {fl, m[4:1], 1'b0, m[0]};
    endfunction : ctl
    function automatic logic near(input logic [15:0] g, input int e);
        return (int'(g) >= e - 3) && (int'(g) <= e + 3);
    endfunction : near
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, page: ARLT_PAGE_TIMER, addr: ad, wdata: d};
        @(posedge sys_clk);
        req <= '0;
    endtask : wr
    task automatic rdp(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
        #1 d = rdata;
    endtask : rdp
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        rdp(ARLT_PAGE_TIMER, ad, d);
    endtask : rd
    task automatic setcnt(input logic [15:0] n);
        wr(ARLT_ADDR_COUNT_LOW, n[7:0]);
        wr(ARLT_ADDR_COUNT_HIGH, n[15:8]);
    endtask : setcnt
    task automatic rdcnt(output logic [15:0] n);
        rd(ARLT_ADDR_COUNT_LOW, n[7:0]);
        rd(ARLT_ADDR_COUNT_HIGH, n[15:8]);
    endtask : rdcnt
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    // ====================
    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails++;
            conclude();
        end
    end

    // ====================
    // scenarios
    initial begin
        rstn = 1'b0;
        req = '0;
        ext_run = 1'b1;
        lf = 16'h003f;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i], v);
            `CHK("reset", ARLT_BYTE_RESET, v)
        end
        wr(ARLT_ADDR_CONTROL, 8'hfb);
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("ctl_rw", ctl(2'b11, 5'b11101), v)
        rdp(8'h01, ARLT_ADDR_CONTROL, v);
        `CHK("page", 8'h00, v)
        rd(8'hc9, v);
        `CHK("unmapped", 8'h00, v)
        wr(ARLT_ADDR_CONTROL, 8'h00);
        repeat (8) begin
            lf = lfsr_next(lf);
            wr(ARLT_ADDR_RELOAD_LOW, lf[7:0]);
            wr(ARLT_ADDR_RELOAD_HIGH, lf[15:8]);
            rd(ARLT_ADDR_RELOAD_LOW, v);
            `CHK("rl_low", lf[7:0], v)
            rd(ARLT_ADDR_RELOAD_HIGH, v);
            `CHK("rl_high", lf[15:8], v)
        end
        // 16-bit rollover with core clock
        wr(ARLT_ADDR_CLOCK_CONTROL, 8'h30);
        wr(ARLT_ADDR_GLOBAL_IRQ, 8'h20);
        wr(ARLT_ADDR_RELOAD_LOW, 8'h10);
        wr(ARLT_ADDR_RELOAD_HIGH, lf[15:8] & 8'h7f);
        setcnt(16'hfffa);
        wr(ARLT_ADDR_CONTROL, ctl(2'b00, 5'b00010));
        repeat (20) @(posedge sys_clk);
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("hi_flag", 7'b1000100, {v[7], v[5:0]})
        `CHK("irq16", 1'b1, irq)
        rdcnt(c);
        `CHK("reload16", 1'b1, c[15:8] == (lf[15:8] & 8'h7f) && c[7:0] > 8'h10)
        repeat (30) @(posedge sys_clk);
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("flag_held", 1'b1, v[7])
        wr(ARLT_ADDR_CONTROL, 8'h00);
        settle();
        `CHK("irq_clr", 1'b0, irq)
        // low byte rollover in 16-bit mode
        setcnt(16'h00fe);
        wr(ARLT_ADDR_CONTROL, ctl(2'b00, 5'b00010));
        repeat (10) @(posedge sys_clk);
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("lo_flag16", ctl(2'b01, 5'b00010), v)
        `CHK("no_lo_irq", 1'b0, irq)
        wr(ARLT_ADDR_CONTROL, ctl(2'b01, 5'b10010));
        settle();
        `CHK("lo_irq16", 1'b1, irq)
        wr(ARLT_ADDR_CONTROL, 8'h00);
        // split mode, high byte stopped first
        setcnt(16'hfcfc);
        wr(ARLT_ADDR_RELOAD_LOW, 8'h40);
        wr(ARLT_ADDR_RELOAD_HIGH, 8'h50);
        wr(ARLT_ADDR_CONTROL, ctl(2'b00, 5'b00100));
        repeat (20) @(posedge sys_clk);
        rd(ARLT_ADDR_COUNT_HIGH, v);
        `CHK("hi_gated", 8'hfc, v)
        rd(ARLT_ADDR_COUNT_LOW, v);
        `CHK("lo_reload", 1'b1, v > 8'h40 && v < 8'h70)
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("split_flags", ctl(2'b01, 5'b00100), v)
        `CHK("split_noirq", 1'b0, irq)
        wr(ARLT_ADDR_CONTROL, ctl(2'b01, 5'b10110));
        settle();
        `CHK("split_loirq", 1'b1, irq)
        repeat (20) @(posedge sys_clk);
        rd(ARLT_ADDR_COUNT_HIGH, v);
        `CHK("hi_reload", 1'b1, v > 8'h50 && v < 8'h70)
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("split_hflag", 1'b1, v[7])
        wr(ARLT_ADDR_CONTROL, 8'h00);
        // counting clock sources: /12, external /8, core overriding
        for (int k = 0; k < 3; k++) begin
            wr(ARLT_ADDR_CLOCK_CONTROL, k == 2 ? 8'h30 : 8'h00);
            setcnt(16'h0000);
            wr(ARLT_ADDR_CONTROL, ctl(2'b00, {3'b000, 1'b1, k != 0}));
            repeat (480) @(posedge sys_clk);
            wr(ARLT_ADDR_CONTROL, 8'h00);
            rdcnt(c);
            `CHK("clk_src", 1'b1, near(c, 480 / divs[k]))
        end
        rd(ARLT_ADDR_RELOAD_LOW, v);
        `CHK("no_capture", 8'h40, v)
        // capture of external /8 against core clock, then core/12; split kept clear
        for (int s = 0; s < 2; s++) begin
            wr(ARLT_ADDR_CLOCK_CONTROL, s == 0 ? 8'h10 : 8'h00);
            setcnt(16'h0000);
            wr(ARLT_ADDR_CONTROL, ctl(2'b00, 5'b01010));
            for (int k = 0; k < 2; k++) begin
                c1 = c;
                v = 8'h00;
                for (int t = 0; t < 60 && !v[7]; t++) rd(ARLT_ADDR_CONTROL, v);
                rd(ARLT_ADDR_RELOAD_LOW, c[7:0]);
                rd(ARLT_ADDR_RELOAD_HIGH, c[15:8]);
                wr(ARLT_ADDR_CONTROL, ctl(2'b00, 5'b01010));
            end
            if (s == 0) begin
                `CHK("capture", 16'(ARLT_EXT_DIV * EXT_PER), c - c1)
            end else begin
                `CHK("capture12", 1'b1, near(c - c1, divs[1] / divs[0]))
            end
        end
        // oscillator stopped: no falling edge of ext/8, so no capture
        ext_run <= 1'b0;
        wr(ARLT_ADDR_CONTROL, ctl(2'b00, 5'b01010));
        repeat (200) @(posedge sys_clk);
        rd(ARLT_ADDR_CONTROL, v);
        `CHK("no_capture_idle", 1'b0, v[7])
        conclude();
    end
endmodule : tb_auto_reload_timer_with_capture
`default_nettype wire
